// >>> hdl/cpurf_pkg.sv
// cpurf_pkg: register map, field positions, reset values and alu op codes
// for the cpu register file; assumes a 32-bit avalon-mm slave front end.
package cpurf_pkg;

    // ------------------------------------------------------------------
    // register word offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_PROGRAM_COUNTER = 8'h00; // pc, 16 bit
    localparam logic [7:0] OFF_STACK_POINTER = 8'h04; // stack pointer, 16 bit
    localparam logic [7:0] OFF_INDEX_BASE_X = 8'h08; // index base x
    localparam logic [7:0] OFF_INDEX_BASE_Y = 8'h0C; // index base y
    localparam logic [7:0] OFF_INTERRUPT_PAGE = 8'h10; // page, 8 bit
    localparam logic [7:0] OFF_REFRESH_COUNTER = 8'h14; // refresh, 8 bit
    localparam logic [7:0] OFF_ACC_FLAGS = 8'h18; // active acc [15:8], flags [7:0]
    localparam logic [7:0] OFF_GP_PAIR0 = 8'h1C; // active pair0
    localparam logic [7:0] OFF_GP_PAIR1 = 8'h20; // active pair1
    localparam logic [7:0] OFF_GP_PAIR2 = 8'h24; // active pair2
    localparam logic [7:0] OFF_CONTROL = 8'h28; // write-only command strobes
    localparam logic [7:0] OFF_STATUS = 8'h2C; // bank selects, refresh state
    localparam logic [7:0] OFF_ALU = 8'h30; // write: op [11:8], operand [7:0]
    localparam logic [7:0] OFF_INDEX_ADDR = 8'h34; // write: disp [7:0], sel [8]
    localparam logic [7:0] OFF_VECTOR_ADDR = 8'h38; // write: low byte
    localparam logic [7:0] OFF_INSTR = 8'h3C; // write: opcode fetch

    // ------------------------------------------------------------------
    // control register bits
    // ------------------------------------------------------------------
    localparam int CTL_SWAP_ACC_BIT = 0; // swap accumulator/flag pair
    localparam int CTL_SWAP_GP_BIT = 1; // swap general purpose set
    localparam int CTL_REFRESH_END_BIT = 2; // end refresh period
    localparam int CTL_LOAD_REFRESH_BIT = 3; // load_refresh_from_accumulator
    localparam int CTL_PUSH_BIT = 4; // stack pointer down by two
    localparam int CTL_POP_BIT = 5; // stack pointer up by two
    localparam int CTL_PC_DRIVEN_BIT = 6; // pc placed on address lines

    // ------------------------------------------------------------------
    // flag bit positions and reset values
    // ------------------------------------------------------------------
    localparam int FLG_CARRY = 0;
    localparam int FLG_SUB = 1;
    localparam int FLG_PARITY = 2;
    localparam int FLG_HALF = 4;
    localparam int FLG_ZERO = 6;
    localparam int FLG_SIGN = 7;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] STACK_STEP = 16'h0002;

    // ------------------------------------------------------------------
    // alu operations
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ALU_ADD = 4'h0,
        ALU_SUB = 4'h1,
        ALU_AND = 4'h2,
        ALU_OR = 4'h3,
        ALU_XOR = 4'h4,
        ALU_CMP = 4'h5,
        ALU_SLA = 4'h6,
        ALU_SRA = 4'h7,
        ALU_SRL = 4'h8,
        ALU_RLC = 4'h9,
        ALU_RRC = 4'hA,
        ALU_INC = 4'hB,
        ALU_DEC = 4'hC,
        ALU_SET = 4'hD,
        ALU_RES = 4'hE,
        ALU_BIT = 4'hF
    } cpurf_alu_op_t;

endpackage : cpurf_pkg

// >>> hdl/cpurf_top.sv
// cpurf_top: programmer-visible register file of an 8-bit cpu with its alu,
// reached by the decoder/control side over a 32-bit avalon-mm slave port.
// assumes one clock, clk_sys, and an asynchronous active-low reset rstn.
//
// Notes on behaviour
// - pc increments after driven on address
// - jump load beats pc increment
// - stack pointer addresses lifo top
// - two index bases plus signed displacement
// - page register gives vector high byte
// - refresh low seven bits increment, wrap
// - refresh msb only changes by load
// - refresh counter on low address, strobe
// - page register on high refresh address
// - two acc/flag pairs, exchange swaps
// - two gp sets, one exchange swaps all
// - gp registers as bytes or pairs
// - acc takes alu result, flags conditions
// - alu op set add..test bit
// - opcode latched into instruction register
// - eighteen bytes plus four words total
// - reset clears pc, page, refresh
`timescale 1ns/1ps

module cpurf_top
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic jump_taken,
    input wire logic [15:0] jump_target,
    output logic [15:0] refresh_addr,
    output logic refresh_strobe_n,
    output logic [15:0] indexed_addr,
    output logic [15:0] vector_addr,
    output logic [7:0] instr_reg,
    output logic instr_valid
);

    // ------------------------------------------------------------------
    // storage: 18 bytes plus 4 words
    // ------------------------------------------------------------------
    logic [15:0] program_counter_r; // fetch address
    logic [15:0] stack_pointer_r; // stack top
    logic [15:0] index_base_x_r;
    logic [15:0] index_base_y_r;
    logic [7:0] interrupt_page_r;
    logic [7:0] refresh_counter_r;
    logic [7:0] acc_r [2]; // index 0 main, 1 alt
    logic [7:0] flags_r [2];
    logic [7:0] gp_r [2][6]; // set, register 0..5
    logic acc_bank_r; // active acc/flag pair
    logic gp_bank_r; // active gp set
    logic refresh_active_r; // refresh period in progress
    logic ack_r; // one-cycle answer

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    wire logic req = avs_read | avs_write;
    wire logic wr_go = avs_write & ~ack_r; // write takes effect once
    wire logic [15:0] wd16 = avs_writedata[15:0];
    wire logic be_lo = avs_byteenable[0];
    wire logic be_hi = avs_byteenable[1];
    wire logic wr_pc = wr_go && avs_address == cpurf_pkg::OFF_PROGRAM_COUNTER;
    wire logic wr_stk = wr_go && avs_address == cpurf_pkg::OFF_STACK_POINTER;
    wire logic wr_xb = wr_go && avs_address == cpurf_pkg::OFF_INDEX_BASE_X;
    wire logic wr_yb = wr_go && avs_address == cpurf_pkg::OFF_INDEX_BASE_Y;
    wire logic wr_pg = wr_go && avs_address == cpurf_pkg::OFF_INTERRUPT_PAGE && be_lo;
    wire logic wr_rf = wr_go && avs_address == cpurf_pkg::OFF_REFRESH_COUNTER && be_lo;
    wire logic wr_af = wr_go && avs_address == cpurf_pkg::OFF_ACC_FLAGS;
    wire logic wr_ctl = wr_go && avs_address == cpurf_pkg::OFF_CONTROL && be_lo;
    wire logic wr_alu = wr_go && avs_address == cpurf_pkg::OFF_ALU && be_lo && be_hi;
    wire logic wr_idx = wr_go && avs_address == cpurf_pkg::OFF_INDEX_ADDR && be_lo && be_hi;
    wire logic wr_vec = wr_go && avs_address == cpurf_pkg::OFF_VECTOR_ADDR && be_lo;
    wire logic wr_ins = wr_go && avs_address == cpurf_pkg::OFF_INSTR && be_lo;
    wire logic ctl_swap_acc = wr_ctl & avs_writedata[cpurf_pkg::CTL_SWAP_ACC_BIT];
    wire logic ctl_swap_gp = wr_ctl & avs_writedata[cpurf_pkg::CTL_SWAP_GP_BIT];
    wire logic ctl_ref_end = wr_ctl & avs_writedata[cpurf_pkg::CTL_REFRESH_END_BIT];
    wire logic ctl_ld_ref = wr_ctl & avs_writedata[cpurf_pkg::CTL_LOAD_REFRESH_BIT];
    wire logic ctl_push = wr_ctl & avs_writedata[cpurf_pkg::CTL_PUSH_BIT];
    wire logic ctl_pop = wr_ctl & avs_writedata[cpurf_pkg::CTL_POP_BIT];
    wire logic ctl_pc_drv = wr_ctl & avs_writedata[cpurf_pkg::CTL_PC_DRIVEN_BIT];

    // gp pair writes: first named register is the high byte
    wire logic [2:0] wr_pair;
    assign wr_pair[0] = wr_go && avs_address == cpurf_pkg::OFF_GP_PAIR0;
    assign wr_pair[1] = wr_go && avs_address == cpurf_pkg::OFF_GP_PAIR1;
    assign wr_pair[2] = wr_go && avs_address == cpurf_pkg::OFF_GP_PAIR2;

    // ------------------------------------------------------------------
    // alu: 8-bit, operand b from write data, a is active accumulator
    // ------------------------------------------------------------------
    cpurf_pkg::cpurf_alu_op_t alu_op;
    logic [7:0] alu_a;
    logic [7:0] alu_b;
    logic [8:0] alu_sum;
    logic [7:0] alu_res;
    logic alu_carry;
    logic alu_half;
    logic alu_keep_acc; // compare and test leave acc alone
    logic [7:0] alu_flags;
    assign alu_op = cpurf_pkg::cpurf_alu_op_t'(avs_writedata[11:8]);
    assign alu_a = acc_r[acc_bank_r];
    assign alu_b = avs_writedata[7:0];

    // operation select
    always_comb
    begin
        alu_sum = 9'h000;
        alu_res = alu_a;
        alu_carry = flags_r[acc_bank_r][cpurf_pkg::FLG_CARRY];
        alu_half = 1'b0;
        alu_keep_acc = 1'b0;
        unique case (alu_op)
            cpurf_pkg::ALU_ADD:
            begin
                alu_sum = {1'b0, alu_a} + {1'b0, alu_b};
                alu_res = alu_sum[7:0];
                alu_carry = alu_sum[8];
                alu_half = ({1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]}) > 5'h0F;
            end
            cpurf_pkg::ALU_SUB, cpurf_pkg::ALU_CMP:
            begin
                alu_sum = {1'b0, alu_a} - {1'b0, alu_b};
                alu_res = alu_sum[7:0];
                alu_carry = alu_sum[8];
                alu_half = alu_a[3:0] < alu_b[3:0];
                alu_keep_acc = (alu_op == cpurf_pkg::ALU_CMP);
            end
            cpurf_pkg::ALU_AND: alu_res = alu_a & alu_b;
            cpurf_pkg::ALU_OR: alu_res = alu_a | alu_b;
            cpurf_pkg::ALU_XOR: alu_res = alu_a ^ alu_b;
            cpurf_pkg::ALU_SLA:
            begin
                alu_res = {alu_a[6:0], 1'b0};
                alu_carry = alu_a[7];
            end
            cpurf_pkg::ALU_SRA:
            begin
                alu_res = {alu_a[7], alu_a[7:1]};
                alu_carry = alu_a[0];
            end
            cpurf_pkg::ALU_SRL:
            begin
                alu_res = {1'b0, alu_a[7:1]};
                alu_carry = alu_a[0];
            end
            cpurf_pkg::ALU_RLC:
            begin
                alu_res = {alu_a[6:0], alu_a[7]};
                alu_carry = alu_a[7];
            end
            cpurf_pkg::ALU_RRC:
            begin
                alu_res = {alu_a[0], alu_a[7:1]};
                alu_carry = alu_a[0];
            end
            cpurf_pkg::ALU_INC: alu_res = alu_a + 8'h01;
            cpurf_pkg::ALU_DEC: alu_res = alu_a - 8'h01;
            cpurf_pkg::ALU_SET: alu_res = alu_a | (8'h01 << alu_b[2:0]);
            cpurf_pkg::ALU_RES: alu_res = alu_a & ~(8'h01 << alu_b[2:0]);
            cpurf_pkg::ALU_BIT:
            begin
                alu_res = alu_a & (8'h01 << alu_b[2:0]);
                alu_keep_acc = 1'b1;
            end
        endcase
    end

    // result conditions, zero included
    always_comb
    begin
        alu_flags = 8'h00;
        alu_flags[cpurf_pkg::FLG_CARRY] = alu_carry;
        alu_flags[cpurf_pkg::FLG_SUB] = (alu_op == cpurf_pkg::ALU_SUB) || (alu_op == cpurf_pkg::ALU_CMP);
        alu_flags[cpurf_pkg::FLG_PARITY] = ~^alu_res;
        alu_flags[cpurf_pkg::FLG_HALF] = alu_half;
        alu_flags[cpurf_pkg::FLG_ZERO] = (alu_res == 8'h00);
        alu_flags[cpurf_pkg::FLG_SIGN] = alu_res[7];
    end

    // ------------------------------------------------------------------
    // address forming
    // ------------------------------------------------------------------
    wire logic [15:0] idx_base = avs_writedata[8] ? index_base_y_r : index_base_x_r;
    wire logic [15:0] idx_disp = {{8{avs_writedata[7]}}, avs_writedata[7:0]}; // signed
    wire logic [7:0] refresh_nxt = {refresh_counter_r[7], refresh_counter_r[6:0] + 7'h01};

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    logic [31:0] rd_nxt;
    always_comb
    begin
        unique case (avs_address)
            cpurf_pkg::OFF_PROGRAM_COUNTER: rd_nxt = {16'h0000, program_counter_r};
            cpurf_pkg::OFF_STACK_POINTER: rd_nxt = {16'h0000, stack_pointer_r};
            cpurf_pkg::OFF_INDEX_BASE_X: rd_nxt = {16'h0000, index_base_x_r};
            cpurf_pkg::OFF_INDEX_BASE_Y: rd_nxt = {16'h0000, index_base_y_r};
            cpurf_pkg::OFF_INTERRUPT_PAGE: rd_nxt = {24'h000000, interrupt_page_r};
            cpurf_pkg::OFF_REFRESH_COUNTER: rd_nxt = {24'h000000, refresh_counter_r};
            cpurf_pkg::OFF_ACC_FLAGS: rd_nxt = {16'h0000, acc_r[acc_bank_r], flags_r[acc_bank_r]};
            cpurf_pkg::OFF_GP_PAIR0: rd_nxt = {16'h0000, gp_r[gp_bank_r][0], gp_r[gp_bank_r][1]};
            cpurf_pkg::OFF_GP_PAIR1: rd_nxt = {16'h0000, gp_r[gp_bank_r][2], gp_r[gp_bank_r][3]};
            cpurf_pkg::OFF_GP_PAIR2: rd_nxt = {16'h0000, gp_r[gp_bank_r][4], gp_r[gp_bank_r][5]};
            cpurf_pkg::OFF_STATUS: rd_nxt = {29'h00000000, refresh_active_r, gp_bank_r, acc_bank_r};
            default: rd_nxt = 32'h00000000; // unmapped and write-only read zero
        endcase
    end

    // ------------------------------------------------------------------
    // bus handshake: waitrequest high until the answering cycle
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            ack_r <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
        end
        else
        begin
            ack_r <= req & ~ack_r;
            avs_waitrequest <= ~(req & ~ack_r);
            avs_readdata <= (avs_read & ~ack_r) ? rd_nxt : avs_readdata;
        end
    end

    // ------------------------------------------------------------------
    // program counter: jump overrides increment
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            program_counter_r <= cpurf_pkg::RST_WORD;
        else if (jump_taken)
            program_counter_r <= jump_target;
        else if (wr_pc)
            program_counter_r <= wd16;
        else if (ctl_pc_drv)
            program_counter_r <= program_counter_r + 16'h0001;
    end

    // ------------------------------------------------------------------
    // stack pointer and index bases
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            stack_pointer_r <= cpurf_pkg::RST_WORD;
            index_base_x_r <= cpurf_pkg::RST_WORD;
            index_base_y_r <= cpurf_pkg::RST_WORD;
        end
        else
        begin
            if (wr_stk)
                stack_pointer_r <= wd16;
            else if (ctl_push)
                stack_pointer_r <= stack_pointer_r - cpurf_pkg::STACK_STEP;
            else if (ctl_pop)
                stack_pointer_r <= stack_pointer_r + cpurf_pkg::STACK_STEP;
            if (wr_xb)
                index_base_x_r <= wd16;
            if (wr_yb)
                index_base_y_r <= wd16;
        end
    end

    // ------------------------------------------------------------------
    // page, refresh counter and refresh outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            interrupt_page_r <= cpurf_pkg::RST_BYTE;
            refresh_counter_r <= cpurf_pkg::RST_BYTE;
            refresh_active_r <= 1'b0;
            refresh_strobe_n <= 1'b1;
            refresh_addr <= cpurf_pkg::RST_WORD;
        end
        else
        begin
            if (wr_pg)
                interrupt_page_r <= avs_writedata[7:0];
            if (ctl_ld_ref)
                refresh_counter_r <= acc_r[acc_bank_r];
            else if (wr_rf)
                refresh_counter_r <= avs_writedata[7:0];
            else if (wr_ins)
                refresh_counter_r <= refresh_nxt[7:0];
            if (wr_ins)
            begin
                refresh_active_r <= 1'b1;
                refresh_strobe_n <= 1'b0;
                refresh_addr <= {interrupt_page_r, refresh_counter_r};
            end
            else if (ctl_ref_end)
            begin
                refresh_active_r <= 1'b0;
                refresh_strobe_n <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // instruction register and address outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            instr_reg <= cpurf_pkg::RST_BYTE;
            instr_valid <= 1'b0;
            indexed_addr <= cpurf_pkg::RST_WORD;
            vector_addr <= cpurf_pkg::RST_WORD;
        end
        else
        begin
            instr_valid <= wr_ins;
            if (wr_ins)
                instr_reg <= avs_writedata[7:0];
            if (wr_idx)
                indexed_addr <= idx_base + idx_disp;
            if (wr_vec)
                vector_addr <= {interrupt_page_r, avs_writedata[7:0]};
        end
    end

    // ------------------------------------------------------------------
    // accumulator/flag pairs and general purpose sets
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            acc_bank_r <= 1'b0;
            gp_bank_r <= 1'b0;
            acc_r <= '{default: 8'h00};
            flags_r <= '{default: 8'h00};
            gp_r <= '{default: '{default: 8'h00}};
        end
        else
        begin
            if (ctl_swap_acc)
                acc_bank_r <= ~acc_bank_r;
            if (ctl_swap_gp)
                gp_bank_r <= ~gp_bank_r;
            if (wr_alu)
            begin
                flags_r[acc_bank_r] <= alu_flags;
                if (!alu_keep_acc)
                    acc_r[acc_bank_r] <= alu_res;
            end
            else if (wr_af)
            begin
                if (be_hi)
                    acc_r[acc_bank_r] <= avs_writedata[15:8];
                if (be_lo)
                    flags_r[acc_bank_r] <= avs_writedata[7:0];
            end
            for (int p = 0; p < 3; p++)
            begin
                if (wr_pair[p] && be_hi)
                    gp_r[gp_bank_r][2 * p] <= avs_writedata[15:8];
                if (wr_pair[p] && be_lo)
                    gp_r[gp_bank_r][2 * p + 1] <= avs_writedata[7:0];
            end
        end
    end

endmodule : cpurf_top

// >>> sim/cpurf_assertions.sv
// checker for cpurf_top: bus answer timing, fetch, refresh and vector capture
// assumes one clock domain and the port names of cpurf_top
`timescale 1ns/1ps
module cpurf_assertions
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic refresh_strobe_n,
    input wire logic [15:0] vector_addr,
    input wire logic [7:0] instr_reg,
    input wire logic instr_valid
);
    // ------------------------------------------------------------------
    // taken requests
    // ------------------------------------------------------------------
    wire logic take = (avs_read | avs_write) & avs_waitrequest; // new request
    wire logic wr_lo = avs_write & take & avs_byteenable[0]; // write with low lane
    wire logic fetch = wr_lo & (avs_address == cpurf_pkg::OFF_INSTR); // opcode fetch
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    chk_answer_next: assert property (take |=> !avs_waitrequest)
        else $error("answer not one cycle after request");
    chk_answer_one: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer held too long");
    chk_no_idle: assert property (!avs_waitrequest |-> $past(avs_read | avs_write))
        else $error("answer without request");
    chk_fetch_latch: assert property (fetch |=> instr_valid && instr_reg == $past(avs_writedata[7:0]))
        else $error("opcode not latched");
    chk_valid_pulse: assert property (instr_valid |=> !instr_valid)
        else $error("fetch pulse too long");
    chk_strobe_fetch: assert property (fetch |=> !refresh_strobe_n)
        else $error("refresh strobe not raised");
    chk_strobe_cause: assert property ($fell(refresh_strobe_n) |-> $past(fetch))
        else $error("refresh strobe without fetch");
    chk_strobe_end: assert property (wr_lo && avs_address == cpurf_pkg::OFF_CONTROL && avs_writedata[2]
        |=> refresh_strobe_n) else $error("refresh strobe not ended");
    chk_vector_low: assert property (wr_lo && avs_address == cpurf_pkg::OFF_VECTOR_ADDR
        |=> vector_addr[7:0] == $past(avs_writedata[7:0])) else $error("vector low byte wrong");
    chk_unmapped_zero: assert property (take && avs_read && avs_address == 8'h40 |=> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    cover property (fetch);
    cover property (take && avs_read);
    cover property (wr_lo && avs_address == cpurf_pkg::OFF_ALU);
endmodule : cpurf_assertions

bind cpurf_top cpurf_assertions u_chk (.clk_sys, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .refresh_strobe_n, .vector_addr, .instr_reg, .instr_valid);

// >>> sim/cpurf_partner.sv
// partner model: the decoder side that orders program jumps
// assumes the bench raises jump_fire just after a clock edge
`timescale 1ns/1ps
module cpurf_partner
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic jump_fire, // bench asks for a jump
    input wire logic [15:0] jump_value, // wanted target
    output logic jump_taken,
    output logic [15:0] jump_target
);
    logic [15:0] last_r; // last target shown
    // remember the target so the idle bus can show its inverse
    always_ff @(posedge clk_sys or negedge rstn)
        if (!rstn)
            last_r <= 16'h0000;
        else if (jump_fire)
            last_r <= jump_value;
    assign jump_taken = jump_fire;
    assign jump_target = jump_fire ? jump_value : ~last_r; // idle target is junk
endmodule : cpurf_partner

// >>> sim/cpurf_top_test.sv
// directed testbench for cpurf_top over avalon-mm
// assumes the partner model drives the jump inputs
`timescale 1ns/1ps
module cpurf_top_test;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, jump_taken, refresh_strobe_n, instr_valid;
    logic jump_fire = 1'b0;
    logic [15:0] jump_value = 16'h4321;
    logic [15:0] jump_target, refresh_addr, indexed_addr, vector_addr;
    logic [7:0] instr_reg;
    int n_mismatch = 0;
    int num_checks = 0;
    int cycles = 0;
    // acc after each alu op from 81 with operand 03 (bit index 3)
    logic [7:0] alu_exp [16] = '{8'h84, 8'h7E, 8'h01, 8'h83, 8'h82, 8'h81, 8'h02, 8'hC0,
        8'h40, 8'h03, 8'hC0, 8'h82, 8'h80, 8'h89, 8'h81, 8'h81};
    cpurf_top u_dut (.clk_sys, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .jump_taken, .jump_target, .refresh_addr, .refresh_strobe_n,
        .indexed_addr, .vector_addr, .instr_reg, .instr_valid);
    cpurf_partner u_far (.clk_sys, .rstn, .jump_fire, .jump_value, .jump_taken, .jump_target);
    always #25 clk_sys = ~clk_sys;
    // ------------------------------------------------------------------
    // bus tasks
    // ------------------------------------------------------------------
    task automatic xfer(input logic rw, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !rw;
        avs_write <= rw;
        do
            @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : xfer
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFF);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        chk(q & m, e);
    endtask : rdchk
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict
    // hang guard
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            n_mismatch++;
            print_verdict();
        end
    end
    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial
    begin
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        rdchk(cpurf_pkg::OFF_PROGRAM_COUNTER, 32'h0);
        rdchk(cpurf_pkg::OFF_INTERRUPT_PAGE, 32'h0);
        rdchk(cpurf_pkg::OFF_REFRESH_COUNTER, 32'h0);
        rdchk(8'h40, 32'h0, 32'hFFFFFFFF);
        $display("reset test done");
        wr(cpurf_pkg::OFF_PROGRAM_COUNTER, 32'hFFFF);
        wr(cpurf_pkg::OFF_CONTROL, 32'h40);
        rdchk(cpurf_pkg::OFF_PROGRAM_COUNTER, 32'h0);
        jump_fire <= 1'b1;
        wr(cpurf_pkg::OFF_CONTROL, 32'h40);
        jump_fire <= 1'b0;
        rdchk(cpurf_pkg::OFF_PROGRAM_COUNTER, 32'h4321);
        wr(cpurf_pkg::OFF_STACK_POINTER, 32'h1000);
        wr(cpurf_pkg::OFF_CONTROL, 32'h10);
        wr(cpurf_pkg::OFF_CONTROL, 32'h10);
        wr(cpurf_pkg::OFF_CONTROL, 32'h20);
        rdchk(cpurf_pkg::OFF_STACK_POINTER, 32'h0FFE);
        wr(cpurf_pkg::OFF_INDEX_BASE_X, 32'h1000);
        wr(cpurf_pkg::OFF_INDEX_BASE_Y, 32'h2000);
        wr(cpurf_pkg::OFF_INDEX_ADDR, 32'h0080);
        chk({16'h0, indexed_addr}, 32'h0F80);
        wr(cpurf_pkg::OFF_INDEX_ADDR, 32'h017F);
        chk({16'h0, indexed_addr}, 32'h207F);
        $display("address test done");
        wr(cpurf_pkg::OFF_INTERRUPT_PAGE, 32'hAB);
        wr(cpurf_pkg::OFF_VECTOR_ADDR, 32'h34);
        chk({16'h0, vector_addr}, 32'hAB34);
        wr(cpurf_pkg::OFF_REFRESH_COUNTER, 32'hFF);
        wr(cpurf_pkg::OFF_INSTR, 32'h3E);
        chk({16'h0, refresh_addr}, 32'hABFF);
        chk({23'h0, refresh_strobe_n, instr_reg}, 32'h3E);
        rdchk(cpurf_pkg::OFF_REFRESH_COUNTER, 32'h80);
        wr(cpurf_pkg::OFF_CONTROL, 32'h04);
        chk({31'h0, refresh_strobe_n}, 32'h1);
        wr(cpurf_pkg::OFF_ACC_FLAGS, 32'h5500);
        wr(cpurf_pkg::OFF_CONTROL, 32'h08);
        rdchk(cpurf_pkg::OFF_REFRESH_COUNTER, 32'h55);
        $display("refresh test done");
        for (int i = 0; i < 16; i++)
        begin
            wr(cpurf_pkg::OFF_ACC_FLAGS, 32'h8100);
            wr(cpurf_pkg::OFF_ALU, {20'h0, i[3:0], 8'h03});
            rdchk(cpurf_pkg::OFF_ACC_FLAGS, {16'h0, alu_exp[i], 8'h00}, 32'hFF00);
        end
        wr(cpurf_pkg::OFF_ACC_FLAGS, 32'h0F00);
        wr(cpurf_pkg::OFF_ALU, 32'h00F1);
        rdchk(cpurf_pkg::OFF_ACC_FLAGS, 32'h0040, 32'hFF40);
        $display("alu test done");
        wr(cpurf_pkg::OFF_ACC_FLAGS, 32'h1122);
        wr(cpurf_pkg::OFF_GP_PAIR0, 32'h3344);
        wr(cpurf_pkg::OFF_CONTROL, 32'h03);
        rdchk(cpurf_pkg::OFF_ACC_FLAGS, 32'h0);
        rdchk(cpurf_pkg::OFF_GP_PAIR0, 32'h0);
        rdchk(cpurf_pkg::OFF_STATUS, 32'h3);
        wr(cpurf_pkg::OFF_GP_PAIR0, 32'h5566);
        wr(cpurf_pkg::OFF_CONTROL, 32'h03);
        rdchk(cpurf_pkg::OFF_ACC_FLAGS, 32'h1122);
        rdchk(cpurf_pkg::OFF_GP_PAIR0, 32'h3344);
        wr(cpurf_pkg::OFF_CONTROL, 32'h02);
        rdchk(cpurf_pkg::OFF_GP_PAIR0, 32'h5566);
        $display("exchange test done");
        print_verdict();
    end
endmodule : cpurf_top_test
